// ===== bench/cds_master.sv
`timescale 1ns/1ps
module cds_master
  import cds_pkg::*;
(
  // Request source
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [1:0]  sz,
  input  wire logic [31:0] ad,
  // Fetch bus side
  output cds_req_t         req
);
  // An idle master shows inverted fields, never the last request
  always_comb begin
    req = go ? {1'b1, wr, sz, ad} : {1'b0, ~wr, ~sz, ~ad};
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, a); end end
module tb;
  import cds_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        BOOT_DONE = 1'b0;
  logic        ig = 1'b0;
  logic        dg = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  sz = SZ_WORD;
  logic [31:0] ad = 32'h0;
  cds_ctl_t    ctl = '0;
  cds_req_t    i_req;
  cds_req_t    d_req;
  cds_rsp_t    i_rsp;
  cds_rsp_t    d_rsp;
  cds_rsp_t    r;
  logic [31:0] start_addr;
  logic        info0_open;
  int          err_total = 0;
  int          check_count = 0;

  always #10 REF_CLK = ~REF_CLK;

  cds_master i_im (.go(ig), .wr(wr), .sz(sz), .ad(ad), .req(i_req));
  cds_master i_dm (.go(dg), .wr(wr), .sz(sz), .ad(ad), .req(d_req));
  cds_decoder i_dut (.REF_CLK(REF_CLK), .RST(RST), .I_REQ(i_req), .I_RSP(i_rsp),
    .D_REQ(d_req), .D_RSP(d_rsp), .CTL(ctl), .BOOT_DONE(BOOT_DONE),
    .START_ADDR(start_addr), .INFO0_OPEN(info0_open));

  // One fetch on the chosen master, judged one cycle later
  task automatic acc(input logic d, input logic w, input logic [1:0] s,
                     input logic [31:0] a, input logic e, input cds_target_t t,
                     input logic [31:0] o);
    ig = !d;
    dg = d;
    wr = w;
    sz = s;
    ad = a;
    @(negedge REF_CLK);
    r = d ? d_rsp : i_rsp;
    `CHK("valid", 1'b1, r.valid)
    `CHK("err", e, r.err)
    `CHK("target", t, r.target)
    if (t != TGT_NONE) `CHK("offset", o[OFS_W-1:0], r.offset)
    if (t == TGT_FLASH) `CHK("page", o[18:13], r.page)
    if (t == TGT_FLASH) `CHK("bank", o >= BANK_BYTES, r.bank)
    `CHK("other port", '0, d ? i_rsp : d_rsp)
  endtask

  task automatic idle(input logic open);
    ig = 1'b0;
    dg = 1'b0;
    ctl.we = 1'b0;
    @(negedge REF_CLK);
    `CHK("idle rsp", '0, {i_rsp, d_rsp})
    `CHK("info0 open", open, info0_open)
  endtask

  task automatic ctlw(input logic [1:0] s, input logic [31:0] v);
    ctl = '{1'b1, s, FLASH_CTL_BASE + ACTL_OFFSET, v};
    @(negedge REF_CLK);
  endtask

  task automatic t_map;
    logic [31:0] ma [11] = '{32'h0, 32'hFFFC, FLASH_BASE, 32'h1003_0000, 32'h1005_FFFC,
      32'h1006_0000, INFO1_BASE, 32'h1080_3FFC, 32'h1080_4000, 32'h1800_0000, 32'h2000_0000};
    cds_target_t mt [11] = '{TGT_BOOT, TGT_BOOT, TGT_FLASH, TGT_FLASH, TGT_FLASH, TGT_NONE,
      TGT_INFO1, TGT_INFO1, TGT_NONE, TGT_NONE, TGT_NONE};
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 11; k++) begin
        acc(d[0], 1'b0, SZ_WORD, ma[k], mt[k] == TGT_NONE, mt[k], ma[k] - (mt[k] == TGT_FLASH ?
          FLASH_BASE : mt[k] == TGT_INFO1 ? INFO1_BASE : BOOT_BASE));
      end
    end
    idle(1'b0);
    $display("t_map done");
  endtask

  task automatic t_size;
    acc(1'b0, 1'b0, SZ_BYTE, FLASH_BASE + 32'h1, 1'b0, TGT_FLASH, 32'h1);
    acc(1'b1, 1'b0, SZ_HALF, FLASH_BASE + 32'h2, 1'b0, TGT_FLASH, 32'h2);
    acc(1'b0, 1'b0, SZ_HALF, FLASH_BASE + 32'h1, 1'b1, TGT_FLASH, 32'h1);
    acc(1'b1, 1'b0, SZ_WORD, FLASH_BASE + 32'h2, 1'b1, TGT_FLASH, 32'h2);
    acc(1'b0, 1'b0, 2'h3, FLASH_BASE, 1'b1, TGT_FLASH, 32'h0);
    acc(1'b1, 1'b1, SZ_WORD, FLASH_BASE, 1'b1, TGT_FLASH, 32'h0);
    idle(1'b0);
    $display("t_size done");
  endtask

  task automatic t_lock;
    acc(1'b1, 1'b0, SZ_WORD, INFO0_BASE + 32'h4, 1'b1, TGT_INFO0, 32'h4);
    ctlw(SZ_WORD, ACTL_KEY1);
    ctlw(SZ_HALF, 32'h0);
    ctlw(SZ_WORD, ACTL_KEY2);
    ctlw(SZ_WORD, ACTL_KEY3);
    idle(1'b1);
    acc(1'b1, 1'b0, SZ_WORD, INFO0_BASE + 32'h4, 1'b0, TGT_INFO0, 32'h4);
    ctlw(SZ_WORD, ACTL_KEY2);
    idle(1'b1);
    ctlw(SZ_WORD, 32'h1234_5678);
    idle(1'b0);
    ctlw(SZ_WORD, ACTL_KEY1);
    ctlw(SZ_WORD, ACTL_KEY3);
    ctlw(SZ_WORD, ACTL_KEY2);
    ctlw(SZ_WORD, ACTL_KEY3);
    idle(1'b0);
    $display("t_lock done");
  endtask

  task automatic t_boot;
    `CHK("start before boot", RESET_VECTOR, start_addr)
    BOOT_DONE = 1'b1;
    @(negedge REF_CLK);
    BOOT_DONE = 1'b0;
    repeat (3) begin
      @(negedge REF_CLK);
      `CHK("start after boot", BOOT_ENTRY, start_addr)
    end
    $display("t_boot done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge REF_CLK);
    `CHK("reset start", RESET_VECTOR, start_addr)
    `CHK("reset rsp", '0, {i_rsp, d_rsp})
    RST = 1'b0;
    t_map();
    t_size();
    t_lock();
    t_boot();
    report_and_stop();
  end
endmodule

// ===== design/cds_decoder.sv
`timescale 1ns/1ps
// Function
// (RULE1) Bytes 0x0000_0000 to 0x1FFF_FFFF form the code region, served for fetches.
// (RULE2) Instruction and data fetches use separate ports, decoded in parallel.
// (RULE3) Main flash decodes at 0x1000_0000-0x1005_FFFF on both fetch paths.
// (RULE4) Flash is two 192KB banks of 24 pages of 8,192 bytes each.
// (RULE5) Flash check-bit storage never appears at any bus address.
// (RULE6) After reset the fetch start address is 0x0000_0000.
// (RULE7) After boot ROM completes, execution continues at 0x1000_0000.
// (RULE8) Info block 0 is decoded at 0x1080_0000-0x1080_1FFF.
// (RULE9) Info block 1 is decoded at 0x1080_2000-0x1080_3FFF.
// (RULE10) A register's address is its peripheral base plus its offset.
// (RULE11) Registers are 32 bits wide unless stated otherwise.
// (RULE12) Byte addressed; word, halfword and byte accesses accepted when aligned.
// (RULE13) Three keys in order unlock info block 0 reads; other words relock.
// (RULE14) Code-region accesses hitting nothing populated get an error response.
module cds_decoder
  import cds_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Instruction-fetch master
  input  wire cds_req_t    I_REQ,
  output cds_rsp_t         I_RSP,
  // Data-fetch master
  input  wire cds_req_t    D_REQ,
  output cds_rsp_t         D_RSP,
  // Flash access-control register write
  input  wire cds_ctl_t    CTL,
  // Boot sequencing and info block 0 lock status
  input  wire logic        BOOT_DONE,
  output logic [31:0]      START_ADDR,
  output logic             INFO0_OPEN
);

  localparam logic [31:0] ACTL_ADDR = FLASH_CTL_BASE + ACTL_OFFSET;

  cds_rsp_t    i_rsp_ff;
  cds_rsp_t    d_rsp_ff;
  cds_lock_t   lock_ff;
  cds_lock_t   nxt_lock;
  logic [31:0] start_ff;
  logic        info0_open_ff;
  logic        ctl_hit;

  // Full decode of one request; flash window ends at 384KB so check bits stay hidden
  function automatic cds_rsp_t decode(input cds_req_t r, input logic open);
    cds_rsp_t    s;
    logic [31:0] a;
    logic [31:0] rel;
    logic        mis;
    s       = '0;
    a       = r.addr;
    rel     = 32'h0;
    s.valid = r.valid;
    mis     = (r.size == SZ_HALF && a[0]) || (r.size == SZ_WORD && a[1:0] != 2'h0)
              || (r.size == 2'h3);                                            // RULE12
    s.err   = 1'b1;
    if (a > CODE_LAST) begin                                                  // RULE1
      s.target = TGT_NONE;
    end else if (a < BOOT_BASE + BOOT_BYTES) begin                            // RULE6
      rel      = a - BOOT_BASE;
      s.target = TGT_BOOT;
      s.offset = rel[OFS_W-1:0];
      s.err    = r.write;
    end else if (a >= FLASH_BASE && a <= FLASH_LAST) begin                    // RULE3 RULE5
      rel      = a - FLASH_BASE;
      s.target = TGT_FLASH;
      s.offset = rel[OFS_W-1:0];
      s.page   = rel[PAGE_SHIFT+5:PAGE_SHIFT];                                // RULE4
      s.bank   = (rel >= BANK_BYTES);                                         // RULE4
      s.err    = r.write;
    end else if (a >= INFO0_BASE && a <= INFO0_LAST) begin                    // RULE8
      rel      = a - INFO0_BASE;
      s.target = TGT_INFO0;
      s.offset = rel[OFS_W-1:0];
      s.err    = r.write || !open;                                            // RULE13
    end else if (a >= INFO1_BASE && a <= INFO1_LAST) begin                    // RULE9
      rel      = a - INFO1_BASE;
      s.target = TGT_INFO1;
      s.offset = rel[OFS_W-1:0];
      s.err    = r.write;
    end else begin
      s.target = TGT_NONE;                                                    // RULE14
    end
    if (mis) begin
      s.err = 1'b1;
    end
    if (!r.valid) begin
      s = '0;
    end
    return s;
  endfunction

  // Both masters are decoded every cycle with no shared arbitration
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      i_rsp_ff <= '0;
    end else begin
      i_rsp_ff <= decode(I_REQ, lock_ff == LK_OPEN);                          // RULE2
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      d_rsp_ff <= '0;
    end else begin
      d_rsp_ff <= decode(D_REQ, lock_ff == LK_OPEN);                          // RULE2
    end
  end

  // Control register sits at base plus offset and takes whole 32-bit words only
  assign ctl_hit = CTL.we && (CTL.addr == ACTL_ADDR) && (CTL.size == SZ_WORD); // RULE10 RULE11

  always_comb begin
    nxt_lock = lock_ff;
    if (ctl_hit) begin
      case (lock_ff)
        LK_LOCKED: nxt_lock = (CTL.wdata == ACTL_KEY1) ? LK_KEY1 : LK_LOCKED;
        LK_KEY1:   nxt_lock = (CTL.wdata == ACTL_KEY2) ? LK_KEY2 :
                              (CTL.wdata == ACTL_KEY1) ? LK_KEY1 : LK_LOCKED;
        LK_KEY2:   nxt_lock = (CTL.wdata == ACTL_KEY3) ? LK_OPEN :
                              (CTL.wdata == ACTL_KEY1) ? LK_KEY1 : LK_LOCKED;
        LK_OPEN: begin
          if (CTL.wdata != ACTL_KEY1 && CTL.wdata != ACTL_KEY2 && CTL.wdata != ACTL_KEY3) begin
            nxt_lock = LK_LOCKED;
          end
        end
        default:   nxt_lock = LK_LOCKED;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lock_ff <= LK_LOCKED;
    end else begin
      lock_ff <= nxt_lock;                                                    // RULE13
    end
  end

  // Open flag is its own flop so the output needs no decode of the lock state
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      info0_open_ff <= 1'b0;
    end else begin
      info0_open_ff <= (nxt_lock == LK_OPEN);                                 // RULE13
    end
  end

  // Fetch start: reset vector until the boot ROM hands over
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      start_ff <= RESET_VECTOR;                                               // RULE6
    end else if (BOOT_DONE) begin
      start_ff <= BOOT_ENTRY;                                                 // RULE7
    end
  end

  assign I_RSP      = i_rsp_ff;
  assign D_RSP      = d_rsp_ff;
  assign START_ADDR = start_ff;
  assign INFO0_OPEN = info0_open_ff;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  code_bound_a: assert property (I_REQ.valid && I_REQ.addr > CODE_LAST |=> I_RSP.err) // RULE1
    else $error("access above code region not refused");

  paths_indep_a: assert property (I_REQ.valid && D_REQ.valid && !I_REQ.write && !D_REQ.write
      && I_REQ.size == SZ_WORD && D_REQ.size == SZ_WORD && I_REQ.addr[1:0] == 2'h0
      && D_REQ.addr == FLASH_BASE && I_REQ.addr == FLASH_BASE
      |=> I_RSP.valid && D_RSP.valid && I_RSP.target == D_RSP.target) // RULE2 RULE3
    else $error("fetch paths decode flash differently");

  flash_hit_a: assert property (D_REQ.valid && D_REQ.addr >= FLASH_BASE && D_REQ.addr <= FLASH_LAST
      |=> D_RSP.target == TGT_FLASH && D_RSP.page < PAGE_COUNT) // RULE3
    else $error("flash window not decoded");

  bank_split_a: assert property (I_REQ.valid && I_REQ.addr == FLASH_BASE + BANK_BYTES
      |=> I_RSP.bank && I_RSP.page == 6'h18) // RULE4
    else $error("second bank start misdecoded");

  no_checkbits_a: assert property (D_REQ.valid && D_REQ.addr == FLASH_LAST + 32'h1
      |=> D_RSP.err && D_RSP.target == TGT_NONE) // RULE5
    else $error("bytes past flash window are mapped");

  reset_vec_a: assert property ($fell(RST) |-> START_ADDR == RESET_VECTOR) // RULE6
    else $error("start address not reset vector");

  boot_entry_a: assert property (BOOT_DONE |=> (START_ADDR == BOOT_ENTRY) [*2]) // RULE7
    else $error("entry point not taken after boot");

  info0_map_a: assert property (D_REQ.valid && !D_REQ.write && D_REQ.size == SZ_WORD
      && D_REQ.addr[1:0] == 2'h0 && D_REQ.addr >= INFO0_BASE && D_REQ.addr <= INFO0_LAST
      |=> D_RSP.target == TGT_INFO0 && (D_RSP.err == !$past(INFO0_OPEN))) // RULE8 RULE13
    else $error("info block 0 decode or lock wrong");

  info1_map_a: assert property (D_REQ.valid && !D_REQ.write && D_REQ.size == SZ_WORD
      && D_REQ.addr[1:0] == 2'h0 && D_REQ.addr >= INFO1_BASE && D_REQ.addr <= INFO1_LAST
      |=> D_RSP.target == TGT_INFO1 && !D_RSP.err) // RULE9
    else $error("info block 1 decode wrong");

  unlock_seq_a: assert property (ctl_hit && CTL.wdata == ACTL_KEY3 && lock_ff == LK_KEY2
      |=> INFO0_OPEN) // RULE13
    else $error("third key did not unlock");

  relock_a: assert property (ctl_hit && CTL.wdata != ACTL_KEY1 && CTL.wdata != ACTL_KEY2
      && CTL.wdata != ACTL_KEY3 |=> !INFO0_OPEN) // RULE13
    else $error("other word did not relock");

  misalign_a: assert property (I_REQ.valid && I_REQ.size == SZ_WORD && I_REQ.addr[1:0] != 2'h0
      |=> I_RSP.err) // RULE12
    else $error("misaligned word accepted");

  hole_err_a: assert property (I_REQ.valid && I_REQ.addr == INFO1_LAST + 32'h1
      |=> I_RSP.err && I_RSP.target == TGT_NONE) // RULE14
    else $error("hole in code region not refused");

  // Data path code bound, write refusals on both paths, instruction boot window
  d_code_bound_a: assert property (D_REQ.valid && D_REQ.addr > CODE_LAST |=> D_RSP.err) // RULE1
    else $error("data access above code region not refused");

  i_write_a: assert property (I_REQ.valid && I_REQ.write |=> I_RSP.err) // RULE14
    else $error("instruction write accepted");

  d_write_a: assert property (D_REQ.valid && D_REQ.write |=> D_RSP.err) // RULE14
    else $error("data write accepted");

  boot_map_a: assert property (I_REQ.valid && I_REQ.addr < BOOT_BASE + BOOT_BYTES
      |=> I_RSP.target == TGT_BOOT) // RULE6
    else $error("boot window misdecoded");

  // Answers follow requests one cycle later and are zero when idle
  i_idle_a: assert property (!I_REQ.valid |=> I_RSP == '0) // RULE2
    else $error("instruction answer without request");

  d_idle_a: assert property (!D_REQ.valid |=> D_RSP == '0) // RULE2
    else $error("data answer without request");

  i_valid_a: assert property (I_REQ.valid |=> I_RSP.valid) // RULE2
    else $error("instruction request not answered");

  d_valid_a: assert property (D_REQ.valid |=> D_RSP.valid) // RULE2
    else $error("data request not answered");

  // Flash geometry, info block 1 map and info block 0 lock
  flash_ofs_a: assert property (D_REQ.valid && D_REQ.addr >= FLASH_BASE
      && D_REQ.addr <= FLASH_LAST |=> D_RSP.offset == $past(D_REQ.addr[OFS_W-1:0])) // RULE4
    else $error("flash offset wrong");

  i_flash_hit_a: assert property (I_REQ.valid && I_REQ.addr >= FLASH_BASE
      && I_REQ.addr <= FLASH_LAST |=> I_RSP.target == TGT_FLASH) // RULE3
    else $error("flash window not decoded on instruction path");

  page_range_a: assert property (I_RSP.valid && I_RSP.target == TGT_FLASH
      |-> I_RSP.page < PAGE_COUNT) // RULE4
    else $error("flash page out of range");

  bank_low_a: assert property (I_RSP.valid && I_RSP.target == TGT_FLASH && I_RSP.page < 6'h18
      |-> !I_RSP.bank) // RULE4
    else $error("first bank page marked second bank");

  i_info1_a: assert property (I_REQ.valid && I_REQ.addr >= INFO1_BASE
      && I_REQ.addr <= INFO1_LAST |=> I_RSP.target == TGT_INFO1) // RULE9
    else $error("info block 1 misdecoded on instruction path");

  info0_lock_a: assert property (!INFO0_OPEN && D_REQ.valid && D_REQ.addr >= INFO0_BASE
      && D_REQ.addr <= INFO0_LAST |=> D_RSP.err) // RULE13
    else $error("locked info block 0 readable");

  // Access size checks
  half_mis_a: assert property (I_REQ.valid && I_REQ.size == SZ_HALF && I_REQ.addr[0]
      |=> I_RSP.err) // RULE12
    else $error("misaligned halfword accepted");

  d_misalign_a: assert property (D_REQ.valid && D_REQ.size == SZ_WORD && D_REQ.addr[1:0] != 2'h0
      |=> D_RSP.err) // RULE12
    else $error("misaligned data word accepted");

  size3_a: assert property (I_REQ.valid && I_REQ.size == 2'h3 |=> I_RSP.err) // RULE12
    else $error("reserved size accepted");

  // Lock and start address hold
  reset_open_a: assert property ($fell(RST) |-> !INFO0_OPEN) // RULE13
    else $error("info block 0 open after reset");

  entry_hold_a: assert property (START_ADDR == BOOT_ENTRY |=> START_ADDR == BOOT_ENTRY) // RULE7
    else $error("entry point lost");

  ctl_size_a: assert property (CTL.we && CTL.size != SZ_WORD |=> $stable(lock_ff)) // RULE11
    else $error("narrow control write changed the lock");

  unlock_cov_c: cover property (lock_ff == LK_KEY2 ##1 INFO0_OPEN);
  dual_fetch_c: cover property (I_RSP.valid && D_RSP.valid && !I_RSP.err && !D_RSP.err);
  boot_hand_c:  cover property (BOOT_DONE ##1 START_ADDR == BOOT_ENTRY);
  hole_hit_c:   cover property (D_RSP.valid && D_RSP.target == TGT_NONE);

endmodule

// ===== include/cds_pkg.sv
package cds_pkg;

  // Code region and its populated windows
  localparam logic [31:0] CODE_LAST      = 32'h1FFF_FFFF;
  localparam logic [31:0] BOOT_BASE      = 32'h0000_0000;
  localparam logic [31:0] BOOT_BYTES     = 32'h0001_0000;
  localparam logic [31:0] FLASH_BASE     = 32'h1000_0000;
  localparam logic [31:0] FLASH_LAST     = 32'h1005_FFFF;
  localparam logic [31:0] INFO0_BASE     = 32'h1080_0000;
  localparam logic [31:0] INFO0_LAST     = 32'h1080_1FFF;
  localparam logic [31:0] INFO1_BASE     = 32'h1080_2000;
  localparam logic [31:0] INFO1_LAST     = 32'h1080_3FFF;

  // Flash geometry
  localparam logic [31:0] BANK_BYTES     = 32'h0003_0000;
  localparam int          PAGE_SHIFT     = 13;
  localparam logic [5:0]  PAGE_COUNT     = 6'h30;
  localparam int          OFS_W          = 19;

  // Reset vector and post-boot entry point
  localparam logic [31:0] RESET_VECTOR   = 32'h0000_0000;
  localparam logic [31:0] BOOT_ENTRY     = 32'h1000_0000;

  // Flash access-control register: peripheral base plus offset
  localparam logic [31:0] FLASH_CTL_BASE = 32'h4002_9000;
  localparam logic [31:0] ACTL_OFFSET    = 32'h0000_0040;
  localparam logic [31:0] ACTL_KEY1      = 32'h3A7F_5CA3;
  localparam logic [31:0] ACTL_KEY2      = 32'hA1E3_4F20;
  localparam logic [31:0] ACTL_KEY3      = 32'h9608_B2C1;

  // Access sizes
  localparam logic [1:0]  SZ_BYTE        = 2'h0;
  localparam logic [1:0]  SZ_HALF        = 2'h1;
  localparam logic [1:0]  SZ_WORD        = 2'h2;

  typedef enum logic [2:0] {
    TGT_NONE  = 3'h0,
    TGT_BOOT  = 3'h1,
    TGT_FLASH = 3'h2,
    TGT_INFO0 = 3'h3,
    TGT_INFO1 = 3'h4
  } cds_target_t;

  typedef enum logic [3:0] {
    LK_LOCKED = 4'h1,
    LK_KEY1   = 4'h2,
    LK_KEY2   = 4'h4,
    LK_OPEN   = 4'h8
  } cds_lock_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
  } cds_req_t;

  typedef struct packed {
    logic             valid;
    logic             err;
    cds_target_t      target;
    logic [OFS_W-1:0] offset;
    logic [5:0]       page;
    logic             bank;
  } cds_rsp_t;

  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cds_ctl_t;

endpackage
